// file: pkg/pin_mux_pkg.sv
// Purpose: constants and types shared by the multifunction pin multiplexer
// Assumes: 8-bit configuration index space reached over a plain register port
// Notes: register offsets are configuration indexes, used as register addresses

package pin_mux_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indexes
  localparam logic [7:0] IDX_SELECT_A = 8'h3C;
  localparam logic [7:0] IDX_SELECT_B = 8'h3D;
  localparam logic [7:0] IDX_OUT_DATA = 8'h3E;
  localparam logic [7:0] IDX_IN_LEVELS = 8'h3F;
  localparam logic [7:0] IDX_MISC_CTRL = 8'h3B;

  ////////////////////////////////////////////////////////////////////////////
  // select register A field positions (low bit of each 2-bit field)
  localparam int POS_CLAIM_ONE_SEL = 0;
  localparam int POS_CLAIM_TWO_SEL = 2;
  localparam int POS_PIN_A_SEL = 4;
  localparam int POS_PIN_B_SEL = 6;
  // select register B field positions
  localparam int POS_ROW6_SEL = 0;
  localparam int POS_ROW7_SEL = 2;
  localparam int POS_PIN_C_SEL = 4;
  localparam int POS_PIN_D_SEL = 6;

  // output-data register bit positions
  localparam int POS_OUT_ROW6 = 0;
  localparam int POS_OUT_ROW7 = 1;
  localparam int POS_OUT_PIN_B = 2;
  localparam int POS_OUT_PIN_C = 3;
  localparam int POS_OUT_PIN_D = 4;
  localparam int POS_OUT_FLUSH = 5;
  localparam int POS_FLUSH_FUNC_LO = 6;
  localparam int POS_FLUSH_FUNC_HI = 7;

  // input-levels register bit positions
  localparam int POS_IN_CLAIM_ZERO = 0;
  localparam int POS_IN_CLAIM_ONE = 1;
  localparam int POS_IN_PIN_A = 2;
  localparam int POS_IN_MOUSE_CLK = 4;
  localparam int POS_IN_MOUSE_DATA = 5;

  // misc control bit positions
  localparam int POS_MOUSE_ENABLE = 0;
  localparam int POS_STOP_PIN_SPEED = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_SELECT_A = 8'h00;
  localparam logic [7:0] RST_SELECT_B = 8'h00;
  localparam logic [7:0] RST_OUT_DATA = 8'h3F;
  localparam logic [7:0] RST_MISC_CTRL = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // function codes of a two-bit select field
  typedef enum logic [1:0] {
    FUNC_FIRST,
    FUNC_SECOND,
    FUNC_THIRD,
    FUNC_FOURTH
  } func_sel_t;

endpackage : pin_mux_pkg

// file: rtl/multifunction_pin_mux.sv
// Purpose: multifunction pin multiplexer with its select and data registers
// Assumes: 40 MHz clk_in; all pin inputs synchronous to clk_in
// Notes: pin paths are combinational so decode timing reaches the pins unchanged

`timescale 1ns/10ps

module multifunction_pin_mux
  import pin_mux_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // multifunction input pins
  input wire logic local_claim_zero_n_in,
  input wire logic claim_one_pin_in,
  input wire logic claim_two_pin_in,
  input wire logic multi_pin_a_in,
  input wire logic mouse_clk_pin_in,
  input wire logic mouse_data_pin_in,
  // internal sources of selectable functions
  input wire logic pmd_write_through_in,
  input wire logic bios_write_through_in,
  input wire logic write_protect_n_in,
  input wire logic cache_ram_select_in,
  input wire logic dram_chip_select_n_in,
  input wire logic row_strobe_six_n_in,
  input wire logic row_strobe_seven_n_in,
  input wire logic flush_n_in,
  input wire logic io_decode_zero_n_in,
  input wire logic io_decode_one_n_in,
  input wire logic mem_decode_zero_hit_in,
  input wire logic mem_decode_one_hit_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic at_cycle_active_in,
  input wire logic dma_master_grant_n_in,
  input wire logic mouse_irq_in,
  input wire logic io_cycle_in,
  input wire logic stop_clock_n_in,
  input wire logic slow_clock_req_in,
  input wire logic mouse_clk_drive_low_in,
  input wire logic mouse_data_drive_low_in,
  input wire logic dram_addr_bit12_in,
  // multifunction output pins
  output logic multi_pin_b_out,
  output logic multi_pin_c_out,
  output logic multi_pin_d_out,
  output logic row_strobe_six_out,
  output logic row_strobe_seven_out,
  output logic flush_pin_out,
  output logic stop_clock_out,
  output logic mouse_clk_out,
  output logic mouse_clk_oe_out,
  output logic mouse_data_out,
  output logic mouse_data_oe_out,
  output logic dram_addr_bit12_out,
  // decoded inputs toward internal logic
  output logic local_claim_n_out,
  output logic time_base_out,
  output logic keyboard_lock_out,
  output logic pm_event_zero_out,
  output logic pm_event_one_out,
  output logic io_to_xd_out,
  output logic mouse_irq_to_link_out
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (ADDR_W < 6) begin : g_addr_check
    $error("ADDR_W too small to reach the register indexes");
  end

  // package slips must stop elaboration, not reach the pins
  if (((1 << POS_CLAIM_ONE_SEL) | (1 << POS_CLAIM_TWO_SEL) |
      (1 << POS_PIN_A_SEL) | (1 << POS_PIN_B_SEL)) != 32'h55) begin : g_sel_a_check
    $error("select A fields overlap or stray");
  end

  if (((1 << POS_ROW6_SEL) | (1 << POS_ROW7_SEL) |
      (1 << POS_PIN_C_SEL) | (1 << POS_PIN_D_SEL)) != 32'h55) begin : g_sel_b_check
    $error("select B fields overlap or stray");
  end

  // six levels plus two flush function bits fill the byte
  if (((1 << POS_OUT_ROW6) | (1 << POS_OUT_ROW7) | (1 << POS_OUT_PIN_B) |
      (1 << POS_OUT_PIN_C) | (1 << POS_OUT_PIN_D) | (1 << POS_OUT_FLUSH) |
      (1 << POS_FLUSH_FUNC_LO) | (1 << POS_FLUSH_FUNC_HI)) != 32'hFF) begin : g_out_check
    $error("output data bits overlap or stray");
  end

  if (POS_IN_CLAIM_ZERO > 7 || POS_IN_CLAIM_ONE > 7 || POS_IN_PIN_A > 7 ||
      POS_IN_MOUSE_CLK > 7 || POS_IN_MOUSE_DATA > 7) begin : g_in_range_check
    $error("input level bit outside the byte");
  end

  if ($countones((1 << POS_IN_CLAIM_ZERO) | (1 << POS_IN_CLAIM_ONE) | (1 << POS_IN_PIN_A) |
      (1 << POS_IN_MOUSE_CLK) | (1 << POS_IN_MOUSE_DATA)) != 5) begin : g_in_overlap_check
    $error("two input level bits overlap");
  end

  if (POS_MOUSE_ENABLE > 7 || POS_STOP_PIN_SPEED > 7 ||
      POS_MOUSE_ENABLE == POS_STOP_PIN_SPEED) begin : g_misc_check
    $error("control bits overlap or stray");
  end

  // a shared index would let one register shadow another
  if (IDX_SELECT_A == IDX_SELECT_B || IDX_SELECT_A == IDX_OUT_DATA ||
      IDX_SELECT_A == IDX_IN_LEVELS || IDX_SELECT_A == IDX_MISC_CTRL ||
      IDX_SELECT_B == IDX_OUT_DATA || IDX_SELECT_B == IDX_IN_LEVELS ||
      IDX_SELECT_B == IDX_MISC_CTRL || IDX_OUT_DATA == IDX_IN_LEVELS ||
      IDX_OUT_DATA == IDX_MISC_CTRL || IDX_IN_LEVELS == IDX_MISC_CTRL) begin : g_idx_check
    $error("two registers share an index");
  end

  if (ADDR_W < 8 && ((IDX_SELECT_A | IDX_SELECT_B | IDX_OUT_DATA | IDX_IN_LEVELS |
      IDX_MISC_CTRL) >> ADDR_W) != 8'h00) begin : g_idx_reach_check
    $error("an index lies beyond the address width");
  end

  // the muxes below rely on the code order of the select type
  if (FUNC_FIRST != 2'h0 || FUNC_SECOND != 2'h1 ||
      FUNC_THIRD != 2'h2 || FUNC_FOURTH != 2'h3) begin : g_code_check
    $error("function codes out of order");
  end

  if (RST_OUT_DATA[5:0] != 6'h3F) begin : g_out_reset_check
    $error("general outputs must reset high");
  end

  // every pin wakes in its first function, mouse pins as inputs
  if (RST_SELECT_A != 8'h00 || RST_SELECT_B != 8'h00 ||
      RST_OUT_DATA[7:6] != 2'h0 || RST_MISC_CTRL != 8'h00) begin : g_reset_check
    $error("select fields must reset to the first function");
  end

  if (RD_UNMAPPED != 8'h00) begin : g_unmapped_check
    $error("unmapped reads must return zero");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0] select_a;
    logic [7:0] select_b;
    logic [7:0] out_data;
    logic [7:0] misc_ctrl;
    logic [7:0] rd_data;
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  logic [1:0] rst_sync_ff;
  logic rst_n;

  // reset release through two flops so the struct leaves reset cleanly
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // field extraction
  func_sel_t sel_claim_one;
  func_sel_t sel_claim_two;
  func_sel_t sel_pin_a;
  func_sel_t sel_pin_b;
  func_sel_t sel_row6;
  func_sel_t sel_row7;
  func_sel_t sel_pin_c;
  func_sel_t sel_pin_d;
  func_sel_t sel_flush;
  logic [7:0] in_levels;
  logic [ADDR_W-1:0] idx;

  assign sel_claim_one = func_sel_t'(state_ff.select_a[POS_CLAIM_ONE_SEL +: 2]);
  assign sel_claim_two = func_sel_t'(state_ff.select_a[POS_CLAIM_TWO_SEL +: 2]);
  assign sel_pin_a = func_sel_t'(state_ff.select_a[POS_PIN_A_SEL +: 2]);
  assign sel_pin_b = func_sel_t'(state_ff.select_a[POS_PIN_B_SEL +: 2]);
  assign sel_row6 = func_sel_t'(state_ff.select_b[POS_ROW6_SEL +: 2]);
  assign sel_row7 = func_sel_t'(state_ff.select_b[POS_ROW7_SEL +: 2]);
  assign sel_pin_c = func_sel_t'(state_ff.select_b[POS_PIN_C_SEL +: 2]);
  assign sel_pin_d = func_sel_t'(state_ff.select_b[POS_PIN_D_SEL +: 2]);
  assign sel_flush = func_sel_t'({state_ff.out_data[POS_FLUSH_FUNC_HI],
                                  state_ff.out_data[POS_FLUSH_FUNC_LO]});

  // raw levels, independent of the selected functions
  always_comb begin
    in_levels = 8'h00;
    in_levels[POS_IN_CLAIM_ZERO] = local_claim_zero_n_in;
    in_levels[POS_IN_CLAIM_ONE] = claim_one_pin_in;
    in_levels[POS_IN_PIN_A] = multi_pin_a_in;
    in_levels[POS_IN_MOUSE_CLK] = mouse_clk_pin_in;
    in_levels[POS_IN_MOUSE_DATA] = mouse_data_pin_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register next state
  always_comb begin
    nxt_state = state_ff;
    idx = reg_addr_in;
    if (reg_wr_in) begin
      if (idx == ADDR_W'(IDX_SELECT_A)) begin
        nxt_state.select_a = reg_wdata_in;
      end else if (idx == ADDR_W'(IDX_SELECT_B)) begin
        nxt_state.select_b = reg_wdata_in;
      end else if (idx == ADDR_W'(IDX_OUT_DATA)) begin
        nxt_state.out_data = reg_wdata_in;
      end else if (idx == ADDR_W'(IDX_MISC_CTRL)) begin
        nxt_state.misc_ctrl = reg_wdata_in;
      end
    end
    // read data stands only in the cycle after the strobe
    nxt_state.rd_data = 8'h00;
    if (reg_rd_in) begin
      if (idx == ADDR_W'(IDX_SELECT_A)) begin
        nxt_state.rd_data = state_ff.select_a;
      end else if (idx == ADDR_W'(IDX_SELECT_B)) begin
        nxt_state.rd_data = state_ff.select_b;
      end else if (idx == ADDR_W'(IDX_OUT_DATA)) begin
        nxt_state.rd_data = state_ff.out_data;
      end else if (idx == ADDR_W'(IDX_IN_LEVELS)) begin
        nxt_state.rd_data = in_levels;
      end else if (idx == ADDR_W'(IDX_MISC_CTRL)) begin
        nxt_state.rd_data = state_ff.misc_ctrl;
      end else begin
        nxt_state.rd_data = RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.select_a <= RST_SELECT_A;
      state_ff.select_b <= RST_SELECT_B;
      state_ff.out_data <= RST_OUT_DATA;
      state_ff.misc_ctrl <= RST_MISC_CTRL;
      state_ff.rd_data <= 8'h00;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata_out = state_ff.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // shared function terms
  logic cache_policy;
  logic isa_enable;
  logic peripheral_io_select_n;
  logic mem_select_zero_n;
  logic mem_select_one_n;

  // kept combinational: must settle inside the first T2
  assign cache_policy = ~(pmd_write_through_in | bios_write_through_in);
  assign isa_enable = at_cycle_active_in | ~dma_master_grant_n_in;
  assign peripheral_io_select_n = |cpu_addr_in[15:10];
  assign mem_select_zero_n = ~mem_decode_zero_hit_in;
  assign mem_select_one_n = ~mem_decode_one_hit_in;

  ////////////////////////////////////////////////////////////////////////////
  // output pin muxes
  always_comb begin
    case (sel_pin_b)
      FUNC_FIRST: multi_pin_b_out = cache_policy;
      FUNC_SECOND: multi_pin_b_out = isa_enable;
      FUNC_THIRD: multi_pin_b_out = mouse_irq_in;
      FUNC_FOURTH: multi_pin_b_out = state_ff.out_data[POS_OUT_PIN_B];
      default: multi_pin_b_out = 1'b1;
    endcase
    case (sel_pin_c)
      FUNC_FIRST: multi_pin_c_out = write_protect_n_in;
      FUNC_SECOND: multi_pin_c_out = cache_ram_select_in;
      FUNC_THIRD: multi_pin_c_out = io_decode_zero_n_in;
      FUNC_FOURTH: multi_pin_c_out = state_ff.out_data[POS_OUT_PIN_C];
      default: multi_pin_c_out = 1'b1;
    endcase
    case (sel_pin_d)
      FUNC_FIRST: multi_pin_d_out = dram_chip_select_n_in;
      FUNC_SECOND: multi_pin_d_out = isa_enable;
      FUNC_THIRD: multi_pin_d_out = io_decode_one_n_in;
      FUNC_FOURTH: multi_pin_d_out = state_ff.out_data[POS_OUT_PIN_D];
      default: multi_pin_d_out = 1'b1;
    endcase
    // row 6 has no second function; left inactive high
    case (sel_row6)
      FUNC_FIRST: row_strobe_six_out = row_strobe_six_n_in;
      FUNC_THIRD: row_strobe_six_out = mem_select_zero_n;
      FUNC_FOURTH: row_strobe_six_out = state_ff.out_data[POS_OUT_ROW6];
      default: row_strobe_six_out = 1'b1;
    endcase
    case (sel_row7)
      FUNC_FIRST: row_strobe_seven_out = row_strobe_seven_n_in;
      FUNC_SECOND: row_strobe_seven_out = peripheral_io_select_n;
      FUNC_THIRD: row_strobe_seven_out = mem_select_one_n;
      FUNC_FOURTH: row_strobe_seven_out = state_ff.out_data[POS_OUT_ROW7];
      default: row_strobe_seven_out = 1'b1;
    endcase
    // reserved flush code parks the pin inactive high
    case (sel_flush)
      FUNC_FIRST: flush_pin_out = flush_n_in;
      FUNC_THIRD: flush_pin_out = io_decode_zero_n_in;
      FUNC_FOURTH: flush_pin_out = state_ff.out_data[POS_OUT_FLUSH];
      default: flush_pin_out = 1'b1;
    endcase
  end

  // stop pin: stop clock or external synthesizer speed select
  assign stop_clock_out = state_ff.misc_ctrl[POS_STOP_PIN_SPEED]
                        ? slow_clock_req_in
                        : stop_clock_n_in;

  // mouse pins open-collector only while mouse enabled, else plain inputs
  assign mouse_clk_out = 1'b0;
  assign mouse_data_out = 1'b0;
  assign mouse_clk_oe_out = state_ff.misc_ctrl[POS_MOUSE_ENABLE] & mouse_clk_drive_low_in;
  assign mouse_data_oe_out = state_ff.misc_ctrl[POS_MOUSE_ENABLE] & mouse_data_drive_low_in;

  assign dram_addr_bit12_out = dram_addr_bit12_in;
  // mouse interrupt goes over the link unless pin B carries it
  assign mouse_irq_to_link_out = (sel_pin_b != FUNC_THIRD) & mouse_irq_in;

  ////////////////////////////////////////////////////////////////////////////
  // input pin decodes
  logic claim_one_n;
  logic claim_two_n;

  // unselected claim pins read as idle so they cannot fake a claim
  assign claim_one_n = (sel_claim_one == FUNC_SECOND) ? claim_one_pin_in : 1'b1;
  assign claim_two_n = (sel_claim_two == FUNC_SECOND) ? claim_two_pin_in : 1'b1;
  assign local_claim_n_out = local_claim_zero_n_in & claim_one_n & claim_two_n;

  assign time_base_out = ((sel_claim_one == FUNC_THIRD) & claim_one_pin_in)
                       | ((sel_pin_a == FUNC_SECOND) & multi_pin_a_in);
  // keyboard controller ignores keys while low; idle high when unselected
  assign keyboard_lock_out = (sel_claim_two == FUNC_THIRD) ? claim_two_pin_in : 1'b1;
  assign pm_event_one_out = (sel_claim_two == FUNC_FOURTH) & claim_two_pin_in;
  assign pm_event_zero_out = (sel_pin_a == FUNC_FOURTH) & multi_pin_a_in;
  // memory and local-bus cycles are never steered
  assign io_to_xd_out = (sel_pin_a == FUNC_THIRD) & ~multi_pin_a_in & io_cycle_in;

endmodule : multifunction_pin_mux

// file: verif/pin_mux_checker.sv
// Purpose: port checker for the multifunction pin multiplexer
// Assumes: shadow copies of the select and output-data registers
// Notes: pins are combinational, so relations hold at every rising edge
`timescale 1ns/10ps
module pin_mux_checker
  import pin_mux_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic local_claim_zero_n_in,
  input wire logic claim_one_pin_in,
  input wire logic claim_two_pin_in,
  input wire logic multi_pin_a_in,
  input wire logic pmd_write_through_in,
  input wire logic bios_write_through_in,
  input wire logic write_protect_n_in,
  input wire logic io_decode_zero_n_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic at_cycle_active_in,
  input wire logic dma_master_grant_n_in,
  input wire logic multi_pin_b_out,
  input wire logic multi_pin_c_out,
  input wire logic multi_pin_d_out,
  input wire logic row_strobe_seven_out,
  input wire logic flush_pin_out,
  input wire logic local_claim_n_out
);
  logic [7:0] sel_a_ff;
  logic [7:0] sel_b_ff;
  logic [7:0] out_ff;
  // shadows reset with the device, and no write is allowed before its registers leave reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_a_ff <= RST_SELECT_A;
      sel_b_ff <= RST_SELECT_B;
      out_ff <= RST_OUT_DATA;
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADDR_W'(IDX_SELECT_A)) sel_a_ff <= reg_wdata_in;
      if (reg_addr_in == ADDR_W'(IDX_SELECT_B)) sel_b_ff <= reg_wdata_in;
      if (reg_addr_in == ADDR_W'(IDX_OUT_DATA)) out_ff <= reg_wdata_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence rd_levels_s;
    reg_rd_in && reg_addr_in == ADDR_W'(IDX_IN_LEVELS);
  endsequence
  sequence levels_ans_s;
    reg_rdata_out[2:0] == $past({multi_pin_a_in, claim_one_pin_in, local_claim_zero_n_in});
  endsequence
  read_levels_a: assert property (rd_levels_s |=> levels_ans_s)
    else $error("level read wrong");
  read_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not cleared");
  cache_policy_a: assert property (sel_a_ff[7:6] == 2'h0 |->
    multi_pin_b_out == !(pmd_write_through_in || bios_write_through_in))
    else $error("cache policy wrong");
  gp_out_b_a: assert property (sel_a_ff[7:6] == 2'h3 |-> multi_pin_b_out == out_ff[2])
    else $error("general output b wrong");
  write_protect_a: assert property (sel_b_ff[5:4] == 2'h0 |->
    multi_pin_c_out == write_protect_n_in)
    else $error("write protect wrong");
  claim_merge_a: assert property (local_claim_n_out == (local_claim_zero_n_in &&
    (sel_a_ff[1:0] != 2'h1 || claim_one_pin_in) && (sel_a_ff[3:2] != 2'h1 || claim_two_pin_in)))
    else $error("claim merge wrong");
  isa_enable_a: assert property (sel_b_ff[7:6] == 2'h1 |->
    multi_pin_d_out == (at_cycle_active_in || !dma_master_grant_n_in))
    else $error("isa enable wrong");
  periph_select_a: assert property (sel_b_ff[3:2] == 2'h1 |->
    row_strobe_seven_out == (|cpu_addr_in[15:10]))
    else $error("peripheral select wrong");
  flush_io_a: assert property (out_ff[7:6] == 2'h2 |-> flush_pin_out == io_decode_zero_n_in)
    else $error("flush pin io select wrong");
endmodule : pin_mux_checker

bind multifunction_pin_mux pin_mux_checker #(.ADDR_W(ADDR_W)) i_checker (.*);

// file: verif/mouse_wire_model.sv
// Purpose: board side of the two open-collector mouse wires
// Assumes: pull-up on each wire; the mouse itself may also pull low
// Notes: no keeper, so a released wire reads high, never the old level
`timescale 1ns/10ps
module mouse_wire_model (
  input wire logic clk_oe_in,
  input wire logic data_oe_in,
  input wire logic dev_clk_low_in,
  input wire logic dev_data_low_in,
  output logic clk_level_out,
  output logic data_level_out
);
  assign clk_level_out = !(clk_oe_in || dev_clk_low_in);
  assign data_level_out = !(data_oe_in || dev_data_low_in);
endmodule : mouse_wire_model

// keyboard side: a key is only taken while the lock line is high
module keyboard_ctrl_model (
  input wire logic lock_n_in,
  input wire logic key_in,
  output logic key_taken_out
);
  assign key_taken_out = lock_n_in && key_in;
endmodule : keyboard_ctrl_model

// file: verif/multifunction_pin_mux_test.sv
// Purpose: self-checking bench for the multifunction pin multiplexer
// Assumes: every pin source comes from one random vector
// Notes: every design output is compared; released mouse wires read high
`timescale 1ns/10ps
module multifunction_pin_mux_test;
  import pin_mux_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [47:0] stim = 48'h0;
  wire logic [19:0] pins;
  logic mclk_lvl;
  logic mouse_data_pin_lvl;
  logic key_taken;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h32;
  logic rd_seen = 1'b0;
  int num_errors = 0;
  int checks = 0;
  assign pins[19] = 1'b0;
  initial forever #12.5 clk_in = ~clk_in;
  multifunction_pin_mux i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .local_claim_zero_n_in(stim[21]), .claim_one_pin_in(stim[22]),
    .claim_two_pin_in(stim[23]), .multi_pin_a_in(stim[24]), .mouse_clk_pin_in(mclk_lvl),
    .mouse_data_pin_in(mouse_data_pin_lvl), .pmd_write_through_in(stim[0]),
    .bios_write_through_in(stim[1]), .write_protect_n_in(stim[2]),
    .cache_ram_select_in(stim[3]), .dram_chip_select_n_in(stim[4]),
    .row_strobe_six_n_in(stim[5]), .row_strobe_seven_n_in(stim[6]), .flush_n_in(stim[7]),
    .io_decode_zero_n_in(stim[8]), .io_decode_one_n_in(stim[9]),
    .mem_decode_zero_hit_in(stim[10]), .mem_decode_one_hit_in(stim[11]),
    .cpu_addr_in({stim[30:25] & {6{stim[31]}}, stim[9:0]}), .at_cycle_active_in(stim[12]),
    .dma_master_grant_n_in(stim[13]), .mouse_irq_in(stim[14]), .io_cycle_in(stim[15]),
    .stop_clock_n_in(stim[16]), .slow_clock_req_in(stim[17]),
    .mouse_clk_drive_low_in(stim[18]), .mouse_data_drive_low_in(stim[19]),
    .dram_addr_bit12_in(stim[20]), .multi_pin_b_out(pins[0]), .multi_pin_c_out(pins[1]),
    .multi_pin_d_out(pins[2]), .row_strobe_six_out(pins[3]), .row_strobe_seven_out(pins[4]),
    .flush_pin_out(pins[5]), .stop_clock_out(pins[6]), .mouse_clk_out(pins[7]),
    .mouse_clk_oe_out(pins[8]), .mouse_data_out(pins[9]), .mouse_data_oe_out(pins[10]),
    .dram_addr_bit12_out(pins[11]), .local_claim_n_out(pins[12]), .time_base_out(pins[13]),
    .keyboard_lock_out(pins[14]), .pm_event_zero_out(pins[15]), .pm_event_one_out(pins[16]),
    .io_to_xd_out(pins[17]), .mouse_irq_to_link_out(pins[18]));
  mouse_wire_model i_wires (.clk_oe_in(pins[8]), .data_oe_in(pins[10]),
    .dev_clk_low_in(stim[32]), .dev_data_low_in(stim[33]),
    .clk_level_out(mclk_lvl), .data_level_out(mouse_data_pin_lvl));
  keyboard_ctrl_model i_kbd (.lock_n_in(pins[14]), .key_in(stim[38]),
    .key_taken_out(key_taken));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  function automatic logic pick(input logic [1:0] c, input logic [3:0] v);
    return v[c];
  endfunction : pick
  // expected pin picture from select codes and sources
  function automatic logic [19:0] model(input logic [7:0] sa, sb, od, mc, input logic [47:0] s);
    logic isa;
    logic [19:0] m;
    isa = s[12] | !s[13];
    m = 20'h0;
    m[0] = pick(sa[7:6], {od[2], s[14], isa, !(s[0] | s[1])});
    m[1] = pick(sb[5:4], {od[3], s[8], s[3], s[2]});
    m[2] = pick(sb[7:6], {od[4], s[9], isa, s[4]});
    m[3] = pick(sb[1:0], {od[0], !s[10], 1'b1, s[5]});
    m[4] = pick(sb[3:2], {od[1], !s[11], |(s[30:25] & {6{s[31]}}), s[6]});
    m[5] = pick(od[7:6], {od[5], s[8], 1'b1, s[7]});
    m[6] = mc[1] ? s[17] : s[16];
    m[8] = mc[0] & s[18];
    m[10] = mc[0] & s[19];
    m[11] = s[20];
    m[12] = s[21] & (sa[1:0] != 2'h1 | s[22]) & (sa[3:2] != 2'h1 | s[23]);
    m[13] = (sa[1:0] == 2'h2 & s[22]) | (sa[5:4] == 2'h1 & s[24]);
    m[14] = sa[3:2] == 2'h2 ? s[23] : 1'b1;
    m[15] = sa[5:4] == 2'h3 ? s[24] : 1'b0;
    m[16] = sa[3:2] == 2'h3 ? s[23] : 1'b0;
    m[17] = sa[5:4] == 2'h2 & !s[24] & s[15];
    m[18] = sa[7:6] != 2'h2 & s[14];
    return m;
  endfunction : model
  task automatic chk(input string name, input logic [19:0] e, input logic [19:0] got);
    checks++;
    if (got !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, e, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr_in <= a;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
  endtask : rd
  // read data stands only in the cycle after the strobe
  always @(negedge clk_in) begin
    if (rd_seen) chk("read data", {12'h000, exp_q.pop_front()}, {12'h000, reg_rdata_out});
    rd_seen = reg_rd_in;
  end
  task automatic check_all(input logic [7:0] sa, sb, od, mc, input logic [47:0] s);
    logic [7:0] lv;
    lv = {2'b00, !(mc[0] & s[19] | s[33]), !(mc[0] & s[18] | s[32]), 1'b0, s[24], s[22], s[21]};
    rd(IDX_SELECT_A, sa);
    rd(IDX_SELECT_B, sb);
    rd(IDX_OUT_DATA, od);
    rd(IDX_MISC_CTRL, mc);
    wr(IDX_IN_LEVELS, ~lv);
    wr({4'h4, s[37:34]}, 8'hA5);
    rd(IDX_IN_LEVELS, lv);
    rd({4'h4, s[37:34]}, RD_UNMAPPED);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk("pins", model(sa, sb, od, mc, s), pins);
    chk("key taken", {19'h0, s[38] & (sa[3:2] != 2'h2 | s[23])}, {19'h0, key_taken});
    @(posedge clk_in);
  endtask : check_all
  task automatic stop_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [47:0] s;
    logic [31:0] r;
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    check_all(RST_SELECT_A, RST_SELECT_B, 8'h3F, 8'h00, stim);
    for (int i = 0; i < 80; i++) begin
      seed = xs(seed);
      s[31:0] = seed;
      seed = xs(seed);
      s[47:32] = seed[15:0];
      seed = xs(seed);
      r = seed;
      stim <= s;
      wr(IDX_SELECT_A, r[7:0]);
      wr(IDX_SELECT_B, r[15:8]);
      wr(IDX_OUT_DATA, r[23:16]);
      wr(IDX_MISC_CTRL, {6'h00, r[25:24]});
      check_all(r[7:0], r[15:8], r[23:16], {6'h00, r[25:24]}, s);
    end
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    check_all(RST_SELECT_A, RST_SELECT_B, 8'h3F, 8'h00, s);
    stop_test();
  end
  // a full run takes about 1100 cycles
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule : multifunction_pin_mux_test
